// *** rtl/out_fmt_pkg.sv ***
// package for the output format configuration register bank
// assumes byte-wide register locations behind the serial configuration port
package out_fmt_pkg;
    localparam logic [7:0] MIX_B_BASE = 8'h31;
    localparam logic [7:0] MAP_A_BASE = 8'h39;
    localparam logic [7:0] MAP_A_LAST = 8'h60;
    localparam logic [7:0] MAP_B_BASE = 8'h61;
    localparam logic [7:0] MAP_B_LAST = 8'h88;
    localparam logic [7:0] FMT_A_ADDR = 8'h8f;
    localparam logic [7:0] FMT_B_ADDR = 8'h92;
    localparam int FMT_BIT = 1;
    localparam logic [7:0] FMT_MASK = 8'h02;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int MIX_BYTES = 4;
    localparam int MAP_DEPTH = 40;
    localparam int SAMPLE_W = 14;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_t;
endpackage

// *** rtl/sample_formatter.sv ***
// one channel output number format stage
// assumes samples arrive in two's complement, one per enabled clock
`timescale 1ns/10ps
`default_nettype none
module sample_formatter #(
    parameter int W = 14
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic offsetBinary,
    input wire logic [W-1:0] sampleIn,
    output var logic [W-1:0] sampleOut
);
    logic [W-1:0] sample_d;

    // offset binary is two's complement with the sign bit flipped
    assign sample_d = {sampleIn[W-1] ^ offsetBinary, sampleIn[W-2:0]};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sampleOut <= '0;
        end else if (ce) begin
            sampleOut <= sample_d;
        end
    end
endmodule
`default_nettype wire

// *** rtl/output_format_config_regs.sv ***
// output format configuration registers: mixer word b, bit reorder tables,
// per-channel output encoding; also formats the two sample streams
// assumes a byte register port already decoded from the serial interface
// and the real decimation and digital bypass controls from elsewhere
`timescale 1ns/10ps
`default_nettype none
module output_format_config_regs #(
    parameter int SW = 14
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire out_fmt_pkg::cfg_req_t cfg,
    input wire logic realDecimation,
    input wire logic digitalBypass,
    input wire logic [SW-1:0] sampleInA,
    input wire logic [SW-1:0] sampleInB,
    output var logic [7:0] rdata,
    output logic [31:0] mixerFreqWordB,
    output logic [out_fmt_pkg::MAP_DEPTH*8-1:0] mapTableA,
    output logic [out_fmt_pkg::MAP_DEPTH*8-1:0] mapTableB,
    output logic [SW-1:0] sampleOutA,
    output logic [SW-1:0] sampleOutB
);
    import out_fmt_pkg::*;

    logic [7:0] mix_q [MIX_BYTES];
    logic [7:0] mapA_q [MAP_DEPTH];
    logic [7:0] mapB_q [MAP_DEPTH];
    logic [7:0] fmtA_q;
    logic [7:0] fmtB_q;
    logic [7:0] rdata_d;

    wire hitMix = cfg.addr >= MIX_B_BASE
                  && cfg.addr < MIX_B_BASE + 8'(MIX_BYTES);
    wire hitMapA = cfg.addr >= MAP_A_BASE && cfg.addr <= MAP_A_LAST;
    wire hitMapB = cfg.addr >= MAP_B_BASE && cfg.addr <= MAP_B_LAST;
    wire hitFmtA = cfg.addr == FMT_A_ADDR;
    wire hitFmtB = cfg.addr == FMT_B_ADDR;
    wire [7:0] mixIdx = cfg.addr - MIX_B_BASE;
    wire [7:0] mapAIdx = cfg.addr - MAP_A_BASE;
    wire [7:0] mapBIdx = cfg.addr - MAP_B_BASE;
    wire wrEn = ce && cfg.wr;
    wire offBinA = fmtA_q[FMT_BIT] && digitalBypass;
    wire offBinB = fmtB_q[FMT_BIT] && digitalBypass;

    genvar i;
    generate
        for (i = 0; i < MIX_BYTES; i++) begin : g_mix
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    mix_q[i] <= REG_RESET;
                end else if (ce && realDecimation) begin
                    // real mode clears word
                    // hardware clear beats a software write in the same cycle
                    mix_q[i] <= REG_RESET;
                end else if (wrEn && hitMix && mixIdx == 8'(i)) begin
                    mix_q[i] <= cfg.wdata;
                end
            end
            assign mixerFreqWordB[8*i+7:8*i] = mix_q[i];
        end
        for (i = 0; i < MAP_DEPTH; i++) begin : g_map
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    mapA_q[i] <= REG_RESET;
                end else if (wrEn && hitMapA && mapAIdx == 8'(i)) begin
                    mapA_q[i] <= cfg.wdata;
                end
            end
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    mapB_q[i] <= REG_RESET;
                end else if (wrEn && hitMapB && mapBIdx == 8'(i)) begin
                    mapB_q[i] <= cfg.wdata;
                end
            end
            assign mapTableA[8*i+7:8*i] = mapA_q[i];
            assign mapTableB[8*i+7:8*i] = mapB_q[i];
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fmtA_q <= REG_RESET;
        end else if (wrEn && hitFmtA) begin
            fmtA_q <= cfg.wdata & FMT_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fmtB_q <= REG_RESET;
        end else if (wrEn && hitFmtB) begin
            fmtB_q <= cfg.wdata & FMT_MASK;
        end
    end

    // unmapped locations read zero rather than holding the last value
    assign rdata_d = hitMix ? mix_q[mixIdx[1:0]] :
                     hitMapA ? mapA_q[mapAIdx[5:0]] :
                     hitMapB ? mapB_q[mapBIdx[5:0]] :
                     hitFmtA ? fmtA_q :
                     hitFmtB ? fmtB_q : REG_RESET;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= REG_RESET;
        end else if (ce && cfg.rd) begin
            rdata <= rdata_d;
        end
    end

    sample_formatter #(.W(SW)) u_fmt_a (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .offsetBinary(offBinA),
        .sampleIn(sampleInA),
        .sampleOut(sampleOutA)
    );

    sample_formatter #(.W(SW)) u_fmt_b (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .offsetBinary(offBinB),
        .sampleIn(sampleInB),
        .sampleOut(sampleOutB)
    );

    a_mix_write_byte: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && !realDecimation && cfg.wr && cfg.addr == MIX_B_BASE + 8'h03
        |=> mixerFreqWordB[31:24] == $past(cfg.wdata))
        else $error("mixer word top byte not written");

    a_mix_real_zero: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && realDecimation |=> mixerFreqWordB == 32'h0)
        else $error("mixer word not cleared in real mode");

    a_map_a_entry: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && cfg.wr && cfg.addr == MAP_A_LAST
        |=> mapTableA[MAP_DEPTH*8-1 -: 8] == $past(cfg.wdata))
        else $error("last channel a table entry not written");

    a_map_b_entry: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && cfg.wr && cfg.addr == MAP_B_BASE
        |=> mapTableB[7:0] == $past(cfg.wdata) && $stable(mapTableA))
        else $error("first channel b table entry not written");

    a_fmt_a_coding: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && fmtA_q[FMT_BIT] && digitalBypass
        |=> sampleOutA == {~$past(sampleInA[SW-1]), $past(sampleInA[SW-2:0])})
        else $error("channel a offset binary wrong");

    a_fmt_b_coding: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && fmtB_q[FMT_BIT] && digitalBypass
        |=> sampleOutB == {~$past(sampleInB[SW-1]), $past(sampleInB[SW-2:0])})
        else $error("channel b offset binary wrong");

    a_bypass_gate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && !digitalBypass |=> sampleOutA == $past(sampleInA)
        && sampleOutB == $past(sampleInB))
        else $error("format applied without digital bypass");

    a_fmt_unused_zero: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && cfg.rd && (hitFmtA || hitFmtB)
        |=> rdata[7:2] == 6'h00 && rdata[0] == 1'b0)
        else $error("unused format bits read nonzero");

    a_mix_read_back: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && cfg.rd && cfg.addr == MIX_B_BASE + 8'h03
        |=> rdata == $past(mixerFreqWordB[31:24]))
        else $error("mixer word top byte read back wrong");

    a_map_a_read: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && cfg.rd && cfg.addr == MAP_A_LAST
        |=> rdata == $past(mapTableA[MAP_DEPTH*8-1 -: 8]))
        else $error("last channel a table entry read back wrong");

    a_map_b_read: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && cfg.rd && cfg.addr == MAP_B_BASE
        |=> rdata == $past(mapTableB[7:0]))
        else $error("first channel b table entry read back wrong");

    a_fmt_a_twos: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && !fmtA_q[FMT_BIT] |=> sampleOutA == $past(sampleInA))
        else $error("channel a twos complement altered");

    a_fmt_b_twos: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && !fmtB_q[FMT_BIT] |=> sampleOutB == $past(sampleInB))
        else $error("channel b twos complement altered");
endmodule
`default_nettype wire

// *** testbench/output_format_config_regs_tb_top.sv ***
// testbench for the output format configuration register bank
// assumes the byte register port at 20 MHz with the clock enable held high except during the clock enable test
`timescale 1ns/10ps
`default_nettype none
module output_format_config_regs_tb_top;
    import out_fmt_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    cfg_req_t cfg = '0;
    logic realDecimation = 1'b0;
    logic digitalBypass = 1'b0;
    logic [13:0] sampleInA = 14'h0000;
    logic [13:0] sampleInB = 14'h0000;
    logic [7:0] rdata;
    logic [31:0] mixerFreqWordB;
    logic [MAP_DEPTH*8-1:0] mapTableA;
    logic [MAP_DEPTH*8-1:0] mapTableB;
    logic [13:0] sampleOutA;
    logic [13:0] sampleOutB;
    logic [7:0] got;
    int nErrors = 0;
    int compares = 0;

    always #25 mclk = ~mclk;

    output_format_config_regs #(.SW(14)) output_format_config_regs_i (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .cfg(cfg),
        .realDecimation(realDecimation),
        .digitalBypass(digitalBypass),
        .sampleInA(sampleInA),
        .sampleInB(sampleInB),
        .rdata(rdata),
        .mixerFreqWordB(mixerFreqWordB),
        .mapTableA(mapTableA),
        .mapTableB(mapTableB),
        .sampleOutA(sampleOutA),
        .sampleOutB(sampleOutB)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            nErrors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic step();
        @(posedge mclk);
        #1;
    endtask

    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        cfg.wr = 1'b1;
        cfg.addr = a;
        cfg.wdata = d;
        step();
        cfg = '0;
        // idle edge so a following request never retoggles wr in one step
        step();
    endtask

    // an extra edge after the request, since rdata holds until the next read
    task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
        cfg.rd = 1'b1;
        cfg.addr = a;
        step();
        cfg = '0;
        step();
        d = rdata;
    endtask

    task automatic testReset();
        for (int a = 8'h31; a <= 8'h92; a++) begin
            rdReg(8'(a), got);
            check(got, REG_RESET);
        end
        $display("test reset done");
    endtask

    task automatic testMixer();
        for (int i = 0; i < 4; i++) begin
            wrReg(8'(MIX_B_BASE + i), 8'(8'h11 * (i + 1)));
        end
        check(mixerFreqWordB, 32'h44332211);
        rdReg(8'h34, got);
        check(got, 8'h44);
        realDecimation = 1'b1;
        wrReg(8'h32, 8'h55);
        step();
        check(mixerFreqWordB, 32'h00000000);
        realDecimation = 1'b0;
        $display("test mixer done");
    endtask

    task automatic testMaps();
        wrReg(MAP_A_BASE, 8'ha1);
        wrReg(MAP_A_LAST, 8'ha2);
        wrReg(MAP_B_BASE, 8'hb1);
        wrReg(MAP_B_LAST, 8'hb2);
        wrReg(8'h89, 8'hff);
        check(mapTableA[7:0], 8'ha1);
        check(mapTableA[319:312], 8'ha2);
        check(mapTableA[15:8], 8'h00);
        check(mapTableB[7:0], 8'hb1);
        check(mapTableB[319:312], 8'hb2);
        rdReg(MAP_A_LAST, got);
        check(got, 8'ha2);
        rdReg(MAP_B_BASE, got);
        check(got, 8'hb1);
        rdReg(8'h89, got);
        check(got, 8'h00);
        $display("test maps done");
    endtask

    task automatic testFormat();
        sampleInA = 14'h2000;
        sampleInB = 14'h1fff;
        digitalBypass = 1'b1;
        wrReg(FMT_A_ADDR, 8'hff);
        rdReg(FMT_A_ADDR, got);
        check(got, FMT_MASK);
        check(sampleOutA, 14'h0000);
        check(sampleOutB, 14'h1fff);
        wrReg(FMT_B_ADDR, 8'h02);
        step();
        check(sampleOutB, 14'h3fff);
        digitalBypass = 1'b0;
        step();
        step();
        check(sampleOutA, 14'h2000);
        check(sampleOutB, 14'h1fff);
        rdReg(FMT_B_ADDR, got);
        check(got, 8'h02);
        $display("test format done");
    endtask

    task automatic testClockEnable();
        sampleInA = 14'h0123;
        rdReg(FMT_B_ADDR, got);
        check(got, 8'h02);
        check(sampleOutA, 14'h0123);
        // low enable must freeze registers, read data and samples
        ce = 1'b0;
        sampleInA = 14'h0456;
        wrReg(8'h62, 8'h77);
        rdReg(MAP_A_LAST, got);
        check(got, 8'h02);
        check(sampleOutA, 14'h0123);
        check(mapTableB[15:8], 8'h00);
        ce = 1'b1;
        step();
        check(sampleOutA, 14'h0456);
        rdReg(8'h62, got);
        check(got, 8'h00);
        $display("test clock enable done");
    endtask

    task automatic testMidReset();
        wrReg(MIX_B_BASE, 8'h5a);
        check(mixerFreqWordB, 32'h0000005a);
        rst_n = 1'b0;
        step();
        check(sampleOutA, 14'h0000);
        step();
        rst_n = 1'b1;
        check(mixerFreqWordB, 32'h00000000);
        check(mapTableA[7:0], 8'h00);
        check(mapTableB[7:0], 8'h00);
        rdReg(FMT_A_ADDR, got);
        check(got, 8'h00);
        $display("test mid reset done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        testReset();
        testMixer();
        testMaps();
        testFormat();
        testClockEnable();
        testMidReset();
        report_and_stop();
    end
endmodule
`default_nettype wire
